// File: dv/pwmtc_core_sva.sv
`timescale 1ns/10ps
module pwmtc_core_sva (
    // bus side
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // power stage side
    input wire logic [5:0]  pwm_out
);
    logic        take;
    logic        rd_take;
    logic        wr_ff;
    logic [11:0] adr_ff;
    logic [5:0]  en_ff;
    logic [5:0]  en_d_ff;
    logic [5:0]  inv_ff;
    logic [2:0]  ctl0_ff;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // transfers taken at this edge
    assign take    = hsel & htrans[1] & hready;
    assign rd_take = take & ~hwrite & (haddr[31:12] == 20'h00000);

    // shadow of enable, invert and generator zero control, written in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff   <= 1'b0;
            adr_ff  <= 12'h000;
            en_ff   <= 6'h00;
            en_d_ff <= 6'h00;
            inv_ff  <= 6'h00;
            ctl0_ff <= 3'h0;
        end else begin
            wr_ff   <= take & hwrite & (haddr[31:12] == 20'h00000);
            adr_ff  <= haddr[11:0];
            en_d_ff <= en_ff;
            if (wr_ff && adr_ff == 12'h000) en_ff <= hwdata[5:0];
            if (wr_ff && adr_ff == 12'h004) inv_ff <= hwdata[5:0];
            if (wr_ff && adr_ff == 12'h040) ctl0_ff <= hwdata[2:0];
        end
    end

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_ready_high: assert property ($past(hresetn) |-> hreadyout)
        else $error("slave not ready");
    a_out_masked: assert property ((pwm_out & ~(en_ff | en_d_ff)) == 6'h00)
        else $error("disabled output driven");
    a_en_readback: assert property (rd_take && haddr[11:0] == 12'h000
        |=> hrdata == {26'h0, $past(en_ff)}) else $error("enable readback wrong");
    a_inv_readback: assert property (rd_take && haddr[11:0] == 12'h004
        |=> hrdata == {26'h0, $past(inv_ff)}) else $error("invert readback wrong");
    a_ctl_readback: assert property (rd_take && haddr[11:0] == 12'h040
        |=> hrdata == {29'h0, $past(ctl0_ff)}) else $error("control readback wrong");
    a_dir_down: assert property (rd_take && haddr[11:0] == 12'h048 && !ctl0_ff[1]
        && !wr_ff |=> hrdata[31:16] == 16'h0000) else $error("direction high in down mode");
    a_unmapped_zero: assert property (take && !hwrite && haddr[31:12] != 20'h0
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    a_rdata_hold: assert property (hreadyout && !(take && !hwrite)
        |=> $stable(hrdata)) else $error("read data moved without read");
endmodule

bind pwmtc_core pwmtc_core_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pwm_out(pwm_out));

// File: dv/pwmtc_core_tb.sv
`timescale 1ns/10ps
module pwmtc_core_tb;
    logic             hclk = 1'b0;
    logic             hresetn = 1'b0;
    logic             hsel = 1'b0;
    logic [31:0]      haddr = 32'h0;
    logic [1:0]       htrans = 2'h0;
    logic             hwrite = 1'b0;
    logic [2:0]       hsize = 3'h2;
    logic [31:0]      hwdata = 32'h0;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
    logic [5:0]       pwm_out;
    logic [5:0][15:0] per_len;
    logic [5:0][15:0] hi_len;
    logic [5:0][15:0] edges;
    logic [31:0]      rd;
    int               mismatches = 0;
    int               n_tests = 0;

    // clock
    always #2 hclk = ~hclk;

    pwmtc_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pwm_out(pwm_out));
    pwmtc_gate_model i_gate (.hclk(hclk), .hresetn(hresetn), .pwm_out(pwm_out),
        .per_len(per_len), .hi_len(hi_len), .edges(edges));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one single transfer, read data left in rd
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        rd = hrdata;
    endtask

    function automatic logic [31:0] ga(input int g, input logic [5:0] ofs);
        return (32'h40 * 32'(g + 1)) + {26'h0, ofs};
    endfunction

    task automatic t_reset();
        bus(1'b0, 32'h0, 32'h0);
        check(rd, 32'h0);
        for (int g = 0; g < 3; g++) begin
            for (int k = 0; k < 9; k++) begin
                bus(1'b0, ga(g, 6'(4 * k)), 32'h0);
                check(rd, 32'h0);
            end
        end
    endtask

    task automatic t_polarity();
        bus(1'b1, 32'h4, 32'h15);
        bus(1'b1, 32'h0, 32'h3F);
        repeat (2) @(posedge hclk);
        check({26'h0, pwm_out}, 32'h15);
        bus(1'b1, 32'h0, 32'h0F);
        repeat (2) @(posedge hclk);
        check({26'h0, pwm_out}, 32'h05);
        bus(1'b1, 32'h1000, 32'h00);
        bus(1'b0, 32'h0, 32'h0);
        check(rd, 32'h0F);
        bus(1'b0, 32'h1000, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, 32'h4, 32'h00);
        bus(1'b1, 32'h0, 32'h3F);
    endtask

    // down mode on each generator: A high from zero to load, B toggles on zero
    task automatic t_down();
        for (int g = 0; g < 3; g++) begin
            bus(1'b1, ga(g, pwmtc_pkg::OFS_LOAD), 32'(3 + g));
            bus(1'b1, ga(g, pwmtc_pkg::OFS_GENA), 32'h00B);
            bus(1'b1, ga(g, pwmtc_pkg::OFS_GENB), 32'h001);
            bus(1'b1, ga(g, pwmtc_pkg::OFS_CTL), 32'h1);
            repeat (40) @(posedge hclk);
            check({16'h0, per_len[2 * g]}, 32'(4 + g));
            check({16'h0, hi_len[2 * g]}, 32'h1);
            check({16'h0, per_len[2 * g + 1]}, 32'(8 + 2 * g));
            check({16'h0, hi_len[2 * g + 1]}, 32'(4 + g));
            bus(1'b0, ga(g, pwmtc_pkg::OFS_COUNT), 32'h0);
            check({31'h0, rd[15:0] <= 16'(3 + g)}, 32'h1);
            check({16'h0, rd[31:16]}, 32'h0);
            bus(1'b1, ga(g, pwmtc_pkg::OFS_CTL), 32'h0);
        end
    endtask

    // up/down on generator zero: high from match A up to match A down
    task automatic t_updown();
        bus(1'b1, ga(0, pwmtc_pkg::OFS_LOAD), 32'h4);
        bus(1'b1, ga(0, pwmtc_pkg::OFS_CMPA), 32'h2);
        bus(1'b1, ga(0, pwmtc_pkg::OFS_GENA), 32'h0B0);
        bus(1'b1, ga(0, pwmtc_pkg::OFS_GENB), 32'h000);
        bus(1'b1, ga(0, pwmtc_pkg::OFS_CTL), 32'h3);
        repeat (80) @(posedge hclk);
        check({16'h0, per_len[0]}, 32'h8);
        check({16'h0, hi_len[0]}, 32'h4);
        bus(1'b1, ga(0, pwmtc_pkg::OFS_CTL), 32'h0);
    endtask

    // generator one: match at zero and match above load must never toggle
    task automatic t_nomatch();
        logic [15:0] e_a;
        logic [15:0] e_b;
        bus(1'b1, ga(1, pwmtc_pkg::OFS_CMPA), 32'h0);
        bus(1'b1, ga(1, pwmtc_pkg::OFS_CMPB), 32'h5);
        bus(1'b1, ga(1, pwmtc_pkg::OFS_GENA), 32'h040);
        bus(1'b1, ga(1, pwmtc_pkg::OFS_GENB), 32'h400);
        bus(1'b1, ga(1, pwmtc_pkg::OFS_CTL), 32'h1);
        repeat (20) @(posedge hclk);
        e_a = edges[2];
        e_b = edges[3];
        repeat (40) @(posedge hclk);
        check({16'h0, edges[2]}, {16'h0, e_a});
        check({16'h0, edges[3]}, {16'h0, e_b});
    endtask

    // dead band on generator two: raw A high 4 of 6, each rise delayed one cycle
    task automatic t_deadband();
        bus(1'b1, ga(2, pwmtc_pkg::OFS_CMPA), 32'h2);
        bus(1'b1, ga(2, pwmtc_pkg::OFS_GENA), 32'h083);
        bus(1'b1, ga(2, pwmtc_pkg::OFS_DBRISE), 32'h1);
        bus(1'b1, ga(2, pwmtc_pkg::OFS_DBFALL), 32'h1);
        bus(1'b1, ga(2, pwmtc_pkg::OFS_CTL), 32'h5);
        repeat (40) @(posedge hclk);
        check({16'h0, per_len[4]}, 32'h6);
        check({16'h0, hi_len[4]}, 32'h3);
        check({16'h0, per_len[5]}, 32'h6);
        check({16'h0, hi_len[5]}, 32'h1);
        bus(1'b1, ga(2, pwmtc_pkg::OFS_CTL), 32'h0);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (5000) @(posedge hclk);
        mismatches++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_polarity();
        t_down();
        t_updown();
        t_nomatch();
        t_deadband();
        end_sim();
    end
endmodule

// File: dv/pwmtc_gate_model.sv
`timescale 1ns/10ps
module pwmtc_gate_model (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // gate drive inputs
    input  wire logic [5:0]       pwm_out,
    // measured figures per output
    output logic      [5:0][15:0] per_len,
    output logic      [5:0][15:0] hi_len,
    output logic      [5:0][15:0] edges
);
    logic [5:0]       prev_ff;
    logic [5:0][15:0] run_ff;
    logic [5:0][15:0] hi_ff;

    // period between rises, width of high time, count of changes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_ff <= '0;
            run_ff  <= '0;
            hi_ff   <= '0;
            per_len <= '0;
            hi_len  <= '0;
            edges   <= '0;
        end else begin
            prev_ff <= pwm_out;
            for (int i = 0; i < 6; i++) begin
                run_ff[i] <= run_ff[i] + 16'h0001;
                hi_ff[i]  <= pwm_out[i] ? hi_ff[i] + 16'h0001 : 16'h0000;
                if (pwm_out[i] != prev_ff[i]) edges[i] <= edges[i] + 16'h0001;
                if (!pwm_out[i] && prev_ff[i]) hi_len[i] <= hi_ff[i];
                if (pwm_out[i] && !prev_ff[i]) begin
                    per_len[i] <= run_ff[i];
                    run_ff[i]  <= 16'h0001;
                end
            end
        end
    end
endmodule

// File: verilog/pwmtc_core.sv
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module pwmtc_core #(
    parameter int unsigned CNT_W = pwmtc_pkg::CNT_W,
    parameter int unsigned DB_W  = pwmtc_pkg::DB_W
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // generator outputs to the power stage
    output logic      [5:0]  pwm_out
);

    localparam int unsigned NG = pwmtc_pkg::NUM_GEN;
    localparam int unsigned NO = pwmtc_pkg::NUM_OUT;

    // applies one two-bit action to a signal level
    function automatic logic act_apply(input logic cur, input logic [1:0] act);
        logic res;
        res = cur;
        case (pwmtc_pkg::pwmtc_act_e'(act))
            pwmtc_pkg::PWMTC_ACT_KEEP:   res = cur;
            pwmtc_pkg::PWMTC_ACT_TOGGLE: res = ~cur;
            pwmtc_pkg::PWMTC_ACT_LOW:    res = 1'b0;
            pwmtc_pkg::PWMTC_ACT_HIGH:   res = 1'b1;
            default:                     res = cur;
        endcase
        return res;
    endfunction

    // next level of one output from its action word and the events
    function automatic logic out_next(input logic                  cur,
                                      input logic [11:0]           acts,
                                      input pwmtc_pkg::pwmtc_evt_s ev,
                                      input logic                  own_b);
        logic v;
        logic a_ev;
        logic b_ev;
        v    = cur;
        a_ev = ev.a_up | ev.a_dn;
        b_ev = ev.b_up | ev.b_dn;
        if (ev.zero) begin
            v = act_apply(v, acts[pwmtc_pkg::ACT_ZERO_POS +: 2]);
        end
        if (ev.load) begin
            v = act_apply(v, acts[pwmtc_pkg::ACT_LOAD_POS +: 2]);
        end
        // on coinciding matches each output follows only its own comparator
        if (a_ev && !(own_b && b_ev)) begin
            v = act_apply(v, ev.a_up ? acts[pwmtc_pkg::ACT_AUP_POS +: 2]
                                     : acts[pwmtc_pkg::ACT_ADN_POS +: 2]);
        end else if (b_ev) begin
            v = act_apply(v, ev.b_up ? acts[pwmtc_pkg::ACT_BUP_POS +: 2]
                                     : acts[pwmtc_pkg::ACT_BDN_POS +: 2]);
        end
        return v;
    endfunction

    // bus side and shared output state
    logic              ap_valid;
    logic              wr_pend_ff;
    logic [11:0]       wr_addr_ff;
    logic [31:0]       hrdata_ff;
    logic              hreadyout_ff;
    logic              hresp_ff;
    logic [NO-1:0]     out_en_ff;
    logic [NO-1:0]     out_inv_ff;
    logic [NO-1:0]     pwm_out_ff;
    logic [NO-1:0]     gen_level;
    logic [31:0]       gen_rd [NG];
    logic [31:0]       rd_word;
    logic [1:0]        rd_gsel;

    // address phase taken when selected, active and bus ready
    assign ap_valid = hsel & htrans[1] & hready;

    // data phase bookkeeping, slave ready with okay in every cycle after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff   <= 1'b0;
            wr_addr_ff   <= 12'h000;
            hreadyout_ff <= 1'b0;
            hresp_ff     <= 1'b0;
        end else begin
            wr_pend_ff   <= ap_valid & hwrite
                            & (haddr[31:12] == 20'h0_0000); // unmapped writes dropped
            if (ap_valid) begin
                wr_addr_ff <= haddr[11:0];
            end
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end
    end

    // read mux from the address phase, unmapped reads give zero
    assign rd_gsel = haddr[7:6] - 2'h1;
    always_comb begin
        rd_word = 32'h0000_0000;
        if (haddr[31:8] == 24'h00_0000) begin
            if (haddr[7:6] != 2'h0) begin
                if (rd_gsel < 2'(NG)) begin
                    rd_word = gen_rd[rd_gsel];
                end
            end else if (haddr[11:0] == pwmtc_pkg::ADDR_OUT_EN) begin
                rd_word = {26'h000_0000, out_en_ff};
            end else if (haddr[11:0] == pwmtc_pkg::ADDR_OUT_INV) begin
                rd_word = {26'h000_0000, out_inv_ff};
            end
        end
    end

    // read data registered so it stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (ap_valid && !hwrite) begin
            hrdata_ff <= rd_word;
        end
    end

    // shared output control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_en_ff  <= pwmtc_pkg::RST_OUT_EN;
            out_inv_ff <= pwmtc_pkg::RST_OUT_INV;
        end else if (wr_pend_ff) begin
            if (wr_addr_ff == pwmtc_pkg::ADDR_OUT_EN) begin
                out_en_ff <= hwdata[NO-1:0];
            end
            if (wr_addr_ff == pwmtc_pkg::ADDR_OUT_INV) begin
                out_inv_ff <= hwdata[NO-1:0];
            end
        end
    end

    // polarity and pin enable on all six outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_out_ff <= 6'h00;
        end else begin
            pwm_out_ff <= (gen_level ^ out_inv_ff) & out_en_ff;
        end
    end

    // ports straight from their flip-flops
    assign pwm_out   = pwm_out_ff;
    assign hrdata    = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp     = hresp_ff;

    // three identical generators
    for (genvar g = 0; g < NG; g++) begin : gen_blk
        // software copies and active copies
        pwmtc_pkg::pwmtc_cfg_s  cfg_ff;
        logic [CNT_W-1:0]       load_sh_ff;
        logic [CNT_W-1:0]       cmpa_sh_ff;
        logic [CNT_W-1:0]       cmpb_sh_ff;
        logic [CNT_W-1:0]       load_ff;
        logic [CNT_W-1:0]       cmpa_ff;
        logic [CNT_W-1:0]       cmpb_ff;
        logic [11:0]            gena_ff;
        logic [11:0]            genb_ff;
        logic [DB_W-1:0]        dbr_ff;
        logic [DB_W-1:0]        dbf_ff;
        // counter state, raw levels and dead-band counts
        logic [CNT_W-1:0]       cnt_ff;
        logic                   dir_ff;
        logic                   raw_a_ff;
        logic                   raw_b_ff;
        logic [DB_W-1:0]        dba_ff;
        logic [DB_W-1:0]        dbb_ff;
        // decode and event wires
        logic                   sel_wr;
        logic                   dir_eff;
        logic                   match_a;
        logic                   match_b;
        logic                   db_a;
        logic                   db_b;
        pwmtc_pkg::pwmtc_evt_s  ev;

        // each generator owns a 0x40 window above the shared registers
        assign sel_wr = wr_pend_ff && (wr_addr_ff[11:8] == 4'h0)
                        && (wr_addr_ff[7:6] == 2'(g + 1));

        // software writes land in the shadow copies for load and matches, directly in control, actions and dead band
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cfg_ff     <= '0;
                load_sh_ff <= CNT_W'(pwmtc_pkg::RST_LOAD);
                cmpa_sh_ff <= CNT_W'(pwmtc_pkg::RST_CMP);
                cmpb_sh_ff <= CNT_W'(pwmtc_pkg::RST_CMP);
                gena_ff    <= pwmtc_pkg::RST_ACT;
                genb_ff    <= pwmtc_pkg::RST_ACT;
                dbr_ff     <= DB_W'(pwmtc_pkg::RST_DB);
                dbf_ff     <= DB_W'(pwmtc_pkg::RST_DB);
            end else if (sel_wr) begin
                case (wr_addr_ff[5:0])
                    pwmtc_pkg::OFS_CTL: begin
                        cfg_ff.run    <= hwdata[pwmtc_pkg::CTL_RUN_BIT];
                        cfg_ff.updown <= hwdata[pwmtc_pkg::CTL_UPDOWN_BIT];
                        cfg_ff.db_en  <= hwdata[pwmtc_pkg::CTL_DBEN_BIT];
                    end
                    pwmtc_pkg::OFS_LOAD:   load_sh_ff <= hwdata[CNT_W-1:0];
                    pwmtc_pkg::OFS_CMPA:   cmpa_sh_ff <= hwdata[CNT_W-1:0];
                    pwmtc_pkg::OFS_CMPB:   cmpb_sh_ff <= hwdata[CNT_W-1:0];
                    pwmtc_pkg::OFS_GENA:   gena_ff    <= hwdata[11:0];
                    pwmtc_pkg::OFS_GENB:   genb_ff    <= hwdata[11:0];
                    pwmtc_pkg::OFS_DBRISE: dbr_ff     <= hwdata[DB_W-1:0];
                    pwmtc_pkg::OFS_DBFALL: dbf_ff     <= hwdata[DB_W-1:0];
                    default: begin
                    end
                endcase
            end
        end

        // events; matches above load can never equal the counter
        assign dir_eff = cfg_ff.updown & dir_ff;
        assign ev.zero = cfg_ff.run && (cnt_ff == '0);
        assign ev.load = cfg_ff.run && (cnt_ff == load_ff);
        assign match_a = cfg_ff.run && (cnt_ff == cmpa_ff) && (cmpa_ff <= load_ff);
        assign match_b = cfg_ff.run && (cnt_ff == cmpb_ff) && (cmpb_ff <= load_ff);
        assign ev.a_up = match_a & dir_eff & ~ev.zero & ~ev.load;
        assign ev.a_dn = match_a & ~dir_eff & ~ev.zero & ~ev.load;
        assign ev.b_up = match_b & dir_eff & ~ev.zero & ~ev.load;
        assign ev.b_dn = match_b & ~dir_eff & ~ev.zero & ~ev.load;

        // active copies follow the shadows only when the count is zero
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                load_ff <= CNT_W'(pwmtc_pkg::RST_LOAD);
                cmpa_ff <= CNT_W'(pwmtc_pkg::RST_CMP);
                cmpb_ff <= CNT_W'(pwmtc_pkg::RST_CMP);
            end else if (cnt_ff == '0) begin
                load_ff <= load_sh_ff;
                cmpa_ff <= cmpa_sh_ff;
                cmpb_ff <= cmpb_sh_ff;
            end
        end

        // counter and direction, one step per cycle while running
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cnt_ff <= CNT_W'(pwmtc_pkg::RST_CNT);
                dir_ff <= pwmtc_pkg::RST_DIR;
            end else if (!cfg_ff.run) begin
                cnt_ff <= cnt_ff;
            end else if (!cfg_ff.updown) begin
                dir_ff <= 1'b0;
                if (cnt_ff == '0) begin
                    cnt_ff <= load_sh_ff;
                end else begin
                    cnt_ff <= cnt_ff - 1'b1;
                end
            end else if (dir_ff) begin
                if (cnt_ff >= load_ff) begin
                    dir_ff <= 1'b0;
                    if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end else begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end else if (cnt_ff == '0) begin
                dir_ff <= 1'b1;
                if (load_sh_ff != '0) begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end else begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end

        // two raw signals sharing the counter
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                raw_a_ff <= 1'b0;
                raw_b_ff <= 1'b0;
            end else begin
                raw_a_ff <= out_next(raw_a_ff, gena_ff, ev, 1'b0);
                raw_b_ff <= out_next(raw_b_ff, genb_ff, ev, 1'b1);
            end
        end

        // dead band: rising edges delayed, second output from inverted first
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                dba_ff <= '0;
                dbb_ff <= '0;
            end else begin
                // rise delay of the first output
                if (!raw_a_ff) begin
                    dba_ff <= '0;
                end else if (dba_ff != dbr_ff) begin
                    dba_ff <= dba_ff + 1'b1;
                end
                // rise delay of the complementary output
                if (raw_a_ff) begin
                    dbb_ff <= '0;
                end else if (dbb_ff != dbf_ff) begin
                    dbb_ff <= dbb_ff + 1'b1;
                end
            end
        end

        // dead-band result or raw level per output
        assign db_a = raw_a_ff & (dba_ff == dbr_ff);
        assign db_b = ~raw_a_ff & (dbb_ff == dbf_ff);
        assign gen_level[2*g]     = cfg_ff.db_en ? db_a : raw_a_ff;
        assign gen_level[2*g + 1] = cfg_ff.db_en ? db_b : raw_b_ff;

        // register readback for this generator
        always_comb begin
            gen_rd[g] = 32'h0000_0000;
            case (haddr[5:0])
                pwmtc_pkg::OFS_CTL:    gen_rd[g] = {29'h0000_0000, cfg_ff};
                pwmtc_pkg::OFS_LOAD:   gen_rd[g] = 32'(load_sh_ff);
                pwmtc_pkg::OFS_COUNT: begin
                    gen_rd[g] = 32'(cnt_ff);
                    gen_rd[g][pwmtc_pkg::COUNT_DIR_BIT] = dir_eff;
                end
                pwmtc_pkg::OFS_CMPA:   gen_rd[g] = 32'(cmpa_sh_ff);
                pwmtc_pkg::OFS_CMPB:   gen_rd[g] = 32'(cmpb_sh_ff);
                pwmtc_pkg::OFS_GENA:   gen_rd[g] = {20'h0_0000, gena_ff};
                pwmtc_pkg::OFS_GENB:   gen_rd[g] = {20'h0_0000, genb_ff};
                pwmtc_pkg::OFS_DBRISE: gen_rd[g] = 32'(dbr_ff);
                pwmtc_pkg::OFS_DBFALL: gen_rd[g] = 32'(dbf_ff);
                default:               gen_rd[g] = 32'h0000_0000;
            endcase
        end
    end

endmodule

// File: verilog/pwmtc_pkg.sv
// What this block does
// - three generators, each counter plus two comparators
// - down mode counts load to zero, reloads
// - up/down mode counts zero to load, back
// - direction low in down mode, toggles otherwise
// - one-cycle pulse when counter equals zero
// - one-cycle pulse when counter equals load
// - down mode load pulse follows zero pulse
// - two comparators pulse when counter equals match
// - up/down matches split by counting direction
// - match above load never pulses
// - two outputs per generator, optional dead band
// - six outputs or three complementary pairs
// - shared polarity and pin enable control
// - zero, load, match events per mode
// - matches coinciding with zero or load ignored
// - per event action: keep, toggle, low, high
// - new load and match values apply at zero
package pwmtc_pkg;

    // sizes
    localparam int unsigned NUM_GEN    = 3;
    localparam int unsigned NUM_OUT    = 6;
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned DB_W       = 12;
    localparam int unsigned ACT_W      = 12;

    // global register byte addresses
    localparam logic [11:0] ADDR_OUT_EN  = 12'h000;
    localparam logic [11:0] ADDR_OUT_INV = 12'h004;

    // per generator offsets inside a 0x40 window, generator g at 0x40*(g+1)
    localparam logic [5:0]  OFS_CTL    = 6'h00;
    localparam logic [5:0]  OFS_LOAD   = 6'h04;
    localparam logic [5:0]  OFS_COUNT  = 6'h08;
    localparam logic [5:0]  OFS_CMPA   = 6'h0C;
    localparam logic [5:0]  OFS_CMPB   = 6'h10;
    localparam logic [5:0]  OFS_GENA   = 6'h14;
    localparam logic [5:0]  OFS_GENB   = 6'h18;
    localparam logic [5:0]  OFS_DBRISE = 6'h1C;
    localparam logic [5:0]  OFS_DBFALL = 6'h20;

    // control field positions and count direction bit
    localparam int unsigned CTL_RUN_BIT    = 0;
    localparam int unsigned CTL_UPDOWN_BIT = 1;
    localparam int unsigned CTL_DBEN_BIT   = 2;
    localparam int unsigned COUNT_DIR_BIT  = 16;

    // action field positions, two bits each
    localparam int unsigned ACT_ZERO_POS = 0;
    localparam int unsigned ACT_LOAD_POS = 2;
    localparam int unsigned ACT_AUP_POS  = 4;
    localparam int unsigned ACT_ADN_POS  = 6;
    localparam int unsigned ACT_BUP_POS  = 8;
    localparam int unsigned ACT_BDN_POS  = 10;

    // values after reset
    localparam logic [CNT_W-1:0]   RST_CNT     = 16'h0000;
    localparam logic               RST_DIR     = 1'b1;
    localparam logic [CNT_W-1:0]   RST_LOAD    = 16'h0000;
    localparam logic [CNT_W-1:0]   RST_CMP     = 16'h0000;
    localparam logic [ACT_W-1:0]   RST_ACT     = 12'h000;
    localparam logic [DB_W-1:0]    RST_DB      = 12'h000;
    localparam logic [NUM_OUT-1:0] RST_OUT_EN  = 6'h00;
    localparam logic [NUM_OUT-1:0] RST_OUT_INV = 6'h00;

    // per event output action
    typedef enum logic [1:0] {
        PWMTC_ACT_KEEP   = 2'h0,
        PWMTC_ACT_TOGGLE = 2'h1,
        PWMTC_ACT_LOW    = 2'h2,
        PWMTC_ACT_HIGH   = 2'h3
    } pwmtc_act_e;

    typedef struct packed {
        logic db_en;
        logic updown;
        logic run;
    } pwmtc_cfg_s;

    typedef struct packed {
        logic zero;
        logic load;
        logic a_up;
        logic a_dn;
        logic b_up;
        logic b_dn;
    } pwmtc_evt_s;

endpackage
